// ---- inc/tcc_map.vh ----
// tcc_map.vh: register offsets, field positions, reset values, mode codes
// assumes: included by the array, memory, checker and testbench files
`ifndef TCC_MAP_VH
`define TCC_MAP_VH
// register offsets (word index on the plain register port)
`define TCC_OFS_SELECT 4'h0
`define TCC_OFS_CTRL 4'h1
`define TCC_OFS_FLAGS 4'h2
`define TCC_OFS_MASK 4'h3
`define TCC_OFS_DATA_LO 4'h4
`define TCC_OFS_DATA_HI 4'h5
`define TCC_OFS_CFG 4'h6
// channel control field positions
`define TCC_CTRL_IEN 7
`define TCC_CTRL_DIR 6
`define TCC_CTRL_CLR 4
`define TCC_CTRL_CMP 3
`define TCC_CTRL_CODE_HI 2
`define TCC_CTRL_CODE_LO 0
// configuration register fields
`define TCC_CFG_DUAL 0
`define TCC_CFG_DAC 1
`define TCC_CFG_XMEM 2
// reset values
`define TCC_CTRL_RST 8'h00
`define TCC_PIN_RST 1'b1
`define TCC_SEL_RST 2'h0
// capture codes
`define TCC_CAP_OFF 3'h0
`define TCC_CAP_FALL 3'h1
`define TCC_CAP_RISE 3'h2
`define TCC_CAP_BOTH 3'h3
`define TCC_CAP_T0 3'h4
`define TCC_CAP_T1 3'h5
`define TCC_CAP_CMPA 3'h6
`define TCC_CAP_CMPB 3'h7
// compare codes
`define TCC_CMP_IRQ 3'h0
`define TCC_CMP_SET 3'h1
`define TCC_CMP_CLR 3'h2
`define TCC_CMP_TOG 3'h3
`define TCC_CMP_PWM_INV 3'h4
`define TCC_CMP_PWM_NON 3'h5
`endif

// ---- rtl/tcc_array.v ----
// tcc_array.v: four-channel compare/capture array on the timer 2 count
// assumes: timer count, tick and direction come from the timer block;
// capture value itself is latched by the timer block on o_capture_event
`include "tcc_map.vh"
module tcc_array #(
    parameter NCH = 4
) (
    input wire i_sys_clk,
    input wire i_reset,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire [7:0] i_timer_count_high,
    input wire [7:0] i_timer_count_low,
    input wire i_timer_tick,
    input wire i_timer_down,
    input wire i_timer0_ovf,
    input wire i_timer1_ovf,
    input wire i_comparator_a_event,
    input wire i_comparator_b_event,
    input wire [NCH-1:0] i_capture_pin,
    output reg o_timer_clear,
    output reg [NCH-1:0] o_capture_event,
    output reg [NCH-1:0] o_compare_pin,
    output wire [NCH-1:0] o_compare_pin_oe,
    output wire o_irq
);
    reg [1:0] channel_select_reg;
    reg [NCH-1:0] channel_flag_reg;
    reg [NCH-1:0] irq_mask_reg;
    reg [2:0] cfg_reg;
    reg [NCH-1:0] event_count_direction;
    reg [NCH-1:0] pin_prev_reg;
    reg [NCH-1:0] pin_next;
    reg [NCH-1:0] channel_event;
    reg [NCH-1:0] dir_next;
    reg rd_ctrl_pending;
    reg [7:0] rdata_next;
    reg [7:0] rdata_reg;
    wire [7:0] rd_ctrl;
    wire [8*NCH-1:0] ctrl_all;
    wire [16*NCH-1:0] value_all;
    wire [15:0] timer_count;
    wire sel_window;
    wire [1:0] wr_field;
    wire mem_wr;
    wire dual_slope;
    wire dac_on;
    wire xmem_on;
    integer k;
    integer m;

    // count formed from high and low bytes
    assign timer_count = {i_timer_count_high, i_timer_count_low};
    assign dual_slope = cfg_reg[`TCC_CFG_DUAL];
    assign dac_on = cfg_reg[`TCC_CFG_DAC];
    assign xmem_on = cfg_reg[`TCC_CFG_XMEM];

    assign sel_window = (i_addr == `TCC_OFS_CTRL);
    assign mem_wr = i_wr && (sel_window || i_addr == `TCC_OFS_DATA_LO ||
        i_addr == `TCC_OFS_DATA_HI);
    assign wr_field = (i_addr == `TCC_OFS_DATA_LO) ? 2'h1 :
        (i_addr == `TCC_OFS_DATA_HI) ? 2'h2 : 2'h0;

    // window tied to the selected channel
    tcc_ctrl_mem #(
        .NCH(NCH),
        .AW(2)
    ) u_mem (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_wr(mem_wr),
        .i_wr_ch(channel_select_reg),
        .i_wr_field(wr_field),
        .i_wr_data(i_wdata),
        .i_rd_ch(channel_select_reg),
        .o_rd_ctrl(rd_ctrl),
        .o_ctrl_all(ctrl_all),
        .o_value_all(value_all)
    );

    // per-channel event detection and pin action
    always @* begin
        pin_next = o_compare_pin;
        channel_event = {NCH{1'b0}};
        dir_next = event_count_direction;
        for (k = 0; k < NCH; k = k + 1) begin
            // mode bit picks compare or capture
            if (ctrl_all[8*k+`TCC_CTRL_CMP]) begin
                // match sampled only on count update
                if (i_timer_tick && value_all[16*k+:16] == timer_count) begin
                    channel_event[k] = 1'b1;
                    case (ctrl_all[8*k+:3])
                        `TCC_CMP_SET: pin_next[k] = 1'b1;
                        `TCC_CMP_CLR: pin_next[k] = 1'b0;
                        `TCC_CMP_TOG: pin_next[k] = ~o_compare_pin[k];
                        // up-count match clears in dual slope, else sets
                        `TCC_CMP_PWM_NON: pin_next[k] =
                            dual_slope ? i_timer_down : 1'b1;
                        `TCC_CMP_PWM_INV: pin_next[k] =
                            dual_slope ? ~i_timer_down : 1'b0;
                        default: pin_next[k] = o_compare_pin[k];
                    endcase
                end
                if (i_timer_tick && !dual_slope && timer_count == 16'h0000
                    && value_all[16*k+:16] != 16'h0000) begin
                    if (ctrl_all[8*k+:3] == `TCC_CMP_PWM_NON) begin
                        pin_next[k] = 1'b0;
                    end else if (ctrl_all[8*k+:3] == `TCC_CMP_PWM_INV) begin
                        pin_next[k] = 1'b1;
                    end
                end
            end else begin
                case (ctrl_all[8*k+:3])
                    `TCC_CAP_FALL: channel_event[k] =
                        pin_prev_reg[k] && !i_capture_pin[k];
                    `TCC_CAP_RISE: channel_event[k] =
                        !pin_prev_reg[k] && i_capture_pin[k];
                    `TCC_CAP_BOTH: channel_event[k] =
                        pin_prev_reg[k] != i_capture_pin[k];
                    `TCC_CAP_T0: channel_event[k] = i_timer0_ovf;
                    `TCC_CAP_T1: channel_event[k] = i_timer1_ovf;
                    `TCC_CAP_CMPA: channel_event[k] = i_comparator_a_event;
                    `TCC_CAP_CMPB: channel_event[k] = i_comparator_b_event;
                    default: channel_event[k] = 1'b0;
                endcase
            end
            // direction recorded on event in dual slope
            if (channel_event[k] && dual_slope) begin
                dir_next[k] = i_timer_down;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_compare_pin <= {NCH{`TCC_PIN_RST}};
            // follow the pin in reset so no false edge follows release
            pin_prev_reg <= i_capture_pin;
            event_count_direction <= {NCH{1'b0}};
            o_timer_clear <= 1'b0;
            o_capture_event <= {NCH{1'b0}};
        end else begin
            o_compare_pin <= pin_next;
            pin_prev_reg <= i_capture_pin;
            event_count_direction <= dir_next;
            // clear timer when enabled channel fires
            o_timer_clear <= 1'b0;
            for (m = 0; m < NCH; m = m + 1) begin
                if (channel_event[m] && ctrl_all[8*m+`TCC_CTRL_CLR]) begin
                    o_timer_clear <= 1'b1;
                end
            end
            o_capture_event <= channel_event & ~ctrl_all_cmp(ctrl_all);
        end
    end

    function [NCH-1:0] ctrl_all_cmp;
        input [8*NCH-1:0] c;
        integer j;
        begin
            for (j = 0; j < NCH; j = j + 1) begin
                ctrl_all_cmp[j] = c[8*j+`TCC_CTRL_CMP];
            end
        end
    endfunction

    // pins given up to DAC or external memory
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_oe
            if (g >= 2) begin : g_dac
                assign o_compare_pin_oe[g] = !xmem_on && !dac_on;
            end else begin : g_plain
                assign o_compare_pin_oe[g] = !xmem_on;
            end
        end
    endgenerate

    // software registers; flags are also set by channel events
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            channel_select_reg <= `TCC_SEL_RST;
            channel_flag_reg <= {NCH{1'b0}};
            irq_mask_reg <= {NCH{1'b0}};
            cfg_reg <= 3'h0;
        end else begin
            if (i_wr && i_addr == `TCC_OFS_SELECT) begin
                channel_select_reg <= i_wdata[1:0];
            end
            if (i_wr && i_addr == `TCC_OFS_MASK) begin
                irq_mask_reg <= i_wdata[NCH-1:0];
            end
            if (i_wr && i_addr == `TCC_OFS_CFG) begin
                cfg_reg <= i_wdata[2:0];
            end
            // events set flags; set wins over write-one clear
            if (i_wr && i_addr == `TCC_OFS_FLAGS) begin
                channel_flag_reg <= (channel_flag_reg & ~i_wdata[NCH-1:0])
                    | channel_event;
            end else begin
                channel_flag_reg <= channel_flag_reg | channel_event;
            end
        end
    end

    assign o_irq = |(channel_flag_reg & irq_mask_reg);

    always @* begin
        case (i_addr)
            `TCC_OFS_SELECT: rdata_next = {6'h00, channel_select_reg};
            `TCC_OFS_FLAGS: rdata_next = {{(8-NCH){1'b0}}, channel_flag_reg};
            `TCC_OFS_MASK: rdata_next = {{(8-NCH){1'b0}}, irq_mask_reg};
            `TCC_OFS_CFG: rdata_next = {5'h00, cfg_reg};
            `TCC_OFS_DATA_LO: rdata_next =
                value_all[16*channel_select_reg+:8];
            `TCC_OFS_DATA_HI: rdata_next =
                value_all[16*channel_select_reg+8+:8];
            default: rdata_next = 8'h00;
        endcase
    end

    // window read data come from memory's register; others registered here
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            rd_ctrl_pending <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            rd_ctrl_pending <= i_rd && sel_window;
            rdata_reg <= i_rd ? rdata_next : 8'h00;
        end
    end

    // direction bit overlays stored bit, so writes have no effect
    wire [7:0] window_view;
    assign window_view = {rd_ctrl[7],
        event_count_direction[channel_select_reg], rd_ctrl[5:0]};

    // window read answers with the selected channel's control
    // both inputs are registers, so the pick adds no read latency
    always @* begin
        o_rdata = rd_ctrl_pending ? window_view : rdata_reg;
    end
endmodule // tcc_array

// ---- rtl/tcc_ctrl_mem.v ----
// tcc_ctrl_mem.v: per-channel control and compare value store
// assumes: single clock, synchronous active-high reset, one write port
`include "tcc_map.vh"
module tcc_ctrl_mem #(
    parameter NCH = 4,
    parameter AW = 2
) (
    input wire i_sys_clk,
    input wire i_reset,
    input wire i_wr,
    input wire [AW-1:0] i_wr_ch,
    input wire [1:0] i_wr_field,
    input wire [7:0] i_wr_data,
    input wire [AW-1:0] i_rd_ch,
    output reg [7:0] o_rd_ctrl,
    output wire [8*NCH-1:0] o_ctrl_all,
    output wire [16*NCH-1:0] o_value_all
);
    reg [7:0] ctrl_reg [0:NCH-1];
    reg [15:0] value_reg [0:NCH-1];
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ent
            always @(posedge i_sys_clk) begin
                if (i_reset) begin
                    ctrl_reg[g] <= `TCC_CTRL_RST;
                    value_reg[g] <= 16'h0000;
                end else if (i_wr && i_wr_ch == g) begin
                    case (i_wr_field)
                        2'h0: ctrl_reg[g] <= i_wr_data;
                        2'h1: value_reg[g][7:0] <= i_wr_data;
                        2'h2: value_reg[g][15:8] <= i_wr_data;
                        default: ctrl_reg[g] <= ctrl_reg[g];
                    endcase
                end
            end
            assign o_ctrl_all[8*g+7:8*g] = ctrl_reg[g];
            assign o_value_all[16*g+15:16*g] = value_reg[g];
        end
    endgenerate
    always @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rd_ctrl <= 8'h00;
        end else begin
            o_rd_ctrl <= ctrl_reg[i_rd_ch];
        end
    end
endmodule // tcc_ctrl_mem

// ---- tb/tcc_array_properties.sv ----
// tcc_array_properties.sv: port-level checker for the compare array
// assumes: bound into tcc_array; config and mask mirrored from writes
`include "tcc_map.vh"
module tcc_array_properties #(
    parameter NCH = 4
) (
    input wire i_sys_clk,
    input wire i_reset,
    input wire [3:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire i_timer_tick,
    input wire i_timer0_ovf,
    input wire i_timer1_ovf,
    input wire i_comparator_a_event,
    input wire i_comparator_b_event,
    input wire [NCH-1:0] i_capture_pin,
    input wire o_timer_clear,
    input wire [NCH-1:0] o_capture_event,
    input wire [NCH-1:0] o_compare_pin,
    input wire [NCH-1:0] o_compare_pin_oe,
    input wire o_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cfg_m;
    logic [NCH-1:0] mask_m;
    logic [NCH-1:0] pin_d;
    wire trig = i_timer0_ovf || i_timer1_ovf || i_comparator_a_event ||
        i_comparator_b_event || (i_capture_pin != pin_d);
    always @(posedge i_sys_clk) begin
        pin_d <= i_capture_pin;
        if (i_reset) begin
            cfg_m <= 3'h0;
            mask_m <= '0;
        end else if (i_wr && i_addr == `TCC_OFS_CFG) begin
            cfg_m <= i_wdata[2:0];
        end else if (i_wr && i_addr == `TCC_OFS_MASK) begin
            mask_m <= i_wdata[NCH-1:0];
        end
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    reset_pins_a: assert property (disable iff (1'b0)
        i_reset |=> o_compare_pin == 4'hF) else $error("pins not high");
    pin_on_tick_a: assert property (
        !$past(i_reset) && o_compare_pin != $past(o_compare_pin)
        |-> $past(i_timer_tick)) else $error("pin moved without tick");
    clear_cause_a: assert property (o_timer_clear |->
        $past(i_timer_tick) || $past(o_capture_event) != 0 ||
        o_capture_event != 0) else $error("timer clear without event");
    capture_cause_a: assert property (o_capture_event != 0 |->
        $past(trig) || $past(trig, 2) || $past(trig, 3))
        else $error("capture without trigger");
    irq_mask_a: assert property (mask_m == 0 |-> !o_irq)
        else $error("irq while fully masked");
    rdata_idle_a: assert property (
        !$past(i_rd) || $past(i_addr) > 4'h6 |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    dac_oe_a: assert property (
        cfg_m[1] |-> o_compare_pin_oe[3:2] == 2'b00)
        else $error("pins c d driven with dac");
    xmem_oe_a: assert property (
        cfg_m[2] |-> o_compare_pin_oe == 4'h0)
        else $error("pins driven with external memory");
    oe_free_a: assert property (
        cfg_m[2:1] == 2'b00 |-> o_compare_pin_oe == 4'hF)
        else $error("pin not driven");
    cover property (o_timer_clear);
    cover property (o_capture_event != 0);
    cover property (o_irq);
    cover property ($fell(o_compare_pin[0]));
endmodule // tcc_array_properties
bind tcc_array tcc_array_properties #(.NCH(NCH)) u_props (
    .i_sys_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_timer_tick, .i_timer0_ovf, .i_timer1_ovf, .i_comparator_a_event,
    .i_comparator_b_event, .i_capture_pin, .o_timer_clear,
    .o_capture_event, .o_compare_pin, .o_compare_pin_oe, .o_irq);

// ---- tb/tcc_timer_model.sv ----
// tcc_timer_model.sv: behavioural timer 2 feeding the compare array
// assumes: one clock; the array's clear request wins over counting
module tcc_timer_model #(
    parameter logic [15:0] TOP = 16'h01FF
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_run,
    input wire logic i_clear,
    output logic [7:0] o_high,
    output logic [7:0] o_low,
    output logic o_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] count_reg;
    assign o_high = count_reg[15:8];
    assign o_low = count_reg[7:0];
    always @(posedge i_sys_clk) begin
        o_tick <= i_run && !i_reset;
        if (i_reset || i_clear)
            count_reg <= 16'h0000;
        else if (i_run)
            count_reg <= (count_reg == TOP) ? 16'h0000 : count_reg + 16'h0001;
    end
endmodule // tcc_timer_model

// ---- tb/testbench.sv ----
// testbench.sv: register-level tests of the compare/capture array
// assumes: timer model closes the count and clear loop with the array
`include "tcc_map.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin \
$display("BAD t=%0t got %h exp %h", $time, (a), (e)); n_mismatch++; end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] TOP = 16'h01FF;
    localparam logic [2:0] CODES [5] = '{`TCC_CMP_SET, `TCC_CMP_TOG,
        `TCC_CMP_TOG, `TCC_CMP_IRQ, `TCC_CMP_CLR};
    localparam logic [4:0] PEXP = 5'b01101;
    logic i_sys_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic run = 1'b0, mon = 1'b0, t0 = 1'b0, t1 = 1'b0, ca = 1'b0, cb = 1'b0;
    logic down = 1'b0;
    logic [3:0] i_addr = 4'h0, cap_pin = 4'hF;
    logic [7:0] i_wdata = 8'h00, o_rdata, th, tl, n_clr;
    logic tick, o_timer_clear, o_irq, hit;
    logic [3:0] o_capture_event, o_compare_pin, o_compare_pin_oe;
    logic [15:0] max_cnt;
    int n_mismatch = 0, n_checks = 0, cycles = 0;
    tcc_array #(.NCH(4)) DUT (
        .i_sys_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_timer_count_high(th), .i_timer_count_low(tl), .i_timer_tick(tick),
        .i_timer_down(down), .i_timer0_ovf(t0), .i_timer1_ovf(t1),
        .i_comparator_a_event(ca), .i_comparator_b_event(cb),
        .i_capture_pin(cap_pin), .o_timer_clear, .o_capture_event,
        .o_compare_pin, .o_compare_pin_oe, .o_irq);
    tcc_timer_model #(.TOP(TOP)) tmr (.i_sys_clk, .i_reset, .i_run(run),
        .i_clear(o_timer_clear), .o_high(th), .o_low(tl), .o_tick(tick));
    always #5 i_sys_clk = ~i_sys_clk;
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // limit covers about 39 timer periods; the test runs 13 plus register traffic
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        max_cnt <= !mon ? 16'h0000 : ({th, tl} > max_cnt) ? {th, tl} : max_cnt;
        n_clr <= mon ? n_clr + 8'(o_timer_clear) : 8'h00;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 `CHK(o_rdata, e)
        @(posedge i_sys_clk);
    endtask
    // compare value 0112 also probes the high byte of the match
    // value rewritten only while the timer stands still
    task automatic setch(input logic [7:0] ch, input logic [7:0] ctrl);
        wr(`TCC_OFS_SELECT, ch);
        wr(`TCC_OFS_CTRL, ctrl);
        wr(`TCC_OFS_DATA_LO, 8'h12);
        wr(`TCC_OFS_DATA_HI, 8'h01);
    endtask
    // one full period visits every count value exactly once
    task automatic run_period();
        run <= 1'b1;
        repeat (TOP + 1) @(posedge i_sys_clk);
        run <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
    endtask
    task automatic cap_try(input int s, output logic h);
        h = 1'b0;
        case (s)
            0: t0 <= 1'b1;
            1: t1 <= 1'b1;
            2: ca <= 1'b1;
            3: cb <= 1'b1;
            4: cap_pin[1] <= 1'b0;
            default: cap_pin[1] <= 1'b1;
        endcase
        @(posedge i_sys_clk);
        {t0, t1, ca, cb} <= 4'h0;
        // the event pulse stands in the cycle right after the trigger edge
        #1 h = o_capture_event[1];
        repeat (5) begin
            @(posedge i_sys_clk);
            #1 h = h | o_capture_event[1];
        end
        @(posedge i_sys_clk);
    endtask
    function automatic logic cap_exp(int c, int s);
        if (c >= 4)
            return s == c - 4;
        return (c == 3 && s >= 4) || (c == 1 && s == 4) || (c == 2 && s == 5);
    endfunction
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        @(posedge i_sys_clk);
        #1 `CHK(o_compare_pin, 4'hF)
        `CHK(o_compare_pin_oe, 4'hF)
        @(posedge i_sys_clk);
        rd_chk(`TCC_OFS_FLAGS, 8'h00);
        rd_chk(4'hF, 8'h00);
        for (int ch = 0; ch < 4; ch++) begin
            setch(8'(ch), {5'h01, `TCC_CMP_CLR});
            run_period();
            `CHK(o_compare_pin, 4'(4'hF << (ch + 1)))
            rd_chk(`TCC_OFS_FLAGS, 8'((2 << ch) - 1));
        end
        for (int i = 0; i < 5; i++) begin
            setch(8'h00, {5'h01, CODES[i]});
            run_period();
            `CHK(o_compare_pin[0], PEXP[i])
        end
        // edge-aligned pwm: match at 0112, bottom at the period's end
        for (int i = 0; i < 2; i++) begin
            setch(8'h00, {5'h01,
                (i != 0) ? `TCC_CMP_PWM_INV : `TCC_CMP_PWM_NON});
            run <= 1'b1;
            repeat (16'h0118) @(posedge i_sys_clk);
            `CHK(o_compare_pin[0], i == 0)
            repeat (TOP - 16'h0117) @(posedge i_sys_clk);
            run <= 1'b0;
            repeat (4) @(posedge i_sys_clk);
            `CHK(o_compare_pin[0], i != 0)
        end
        wr(`TCC_OFS_MASK, 8'h01);
        `CHK(o_irq, 1'b1)
        wr(`TCC_OFS_MASK, 8'h00);
        `CHK(o_irq, 1'b0)
        wr(`TCC_OFS_MASK, 8'h01);
        wr(`TCC_OFS_FLAGS, 8'h01);
        `CHK(o_irq, 1'b0)
        setch(8'h00, {5'h03, `TCC_CMP_IRQ});
        mon <= 1'b1;
        run_period();
        `CHK(max_cnt < 16'h0118, 1'b1)
        `CHK(n_clr != 8'h00, 1'b1)
        mon <= 1'b0;
        setch(8'h00, {5'h01, `TCC_CMP_IRQ});
        wr(`TCC_OFS_CFG, 8'h02);
        `CHK(o_compare_pin_oe, 4'h3)
        wr(`TCC_OFS_CFG, 8'h04);
        `CHK(o_compare_pin_oe, 4'h0)
        wr(`TCC_OFS_FLAGS, 8'h0F);
        run_period();
        rd_chk(`TCC_OFS_FLAGS, 8'h0F);
        wr(`TCC_OFS_CFG, 8'h00);
        `CHK(o_compare_pin_oe, 4'hF)
        for (int c = 0; c < 8; c++) begin
            setch(8'h01, 8'(c));
            for (int s = 0; s < 6; s++) begin
                cap_try(s, hit);
                `CHK(hit, cap_exp(c, s))
            end
        end
        // dual slope: a down-count event on channel 1 records direction
        wr(`TCC_OFS_CFG, 8'h01);
        down <= 1'b1;
        cap_try(3, hit);
        `CHK(hit, 1'b1)
        rd_chk(`TCC_OFS_CTRL, 8'h47);
        wr(`TCC_OFS_CTRL, 8'h07);
        rd_chk(`TCC_OFS_CTRL, 8'h47);
        wr(`TCC_OFS_SELECT, 8'h02);
        wr(`TCC_OFS_CTRL, 8'h4A);
        rd_chk(`TCC_OFS_CTRL, 8'h0A);
        wr(`TCC_OFS_SELECT, 8'h00);
        rd_chk(`TCC_OFS_CTRL, 8'h08);
        tally_and_finish();
    end
endmodule // testbench
